// [hdl/asr_pkg.sv]
// Purpose: Shared constants for the acceleration sample readout registers
// Assumes: Byte-wide register space, 8-bit register addresses
// Notes: Offsets are byte addresses of single-byte registers
package asr_pkg;
   localparam int ASR_AW = 8;
   localparam int ASR_DW = 8;
   localparam int ASR_SW = 14;
   localparam int ASR_CW = 10;
   localparam logic [9:0] ASR_COUNT_MAX = 10'h200;

   // Register offsets
   localparam logic [7:0] ASR_OFS_X8 = 8'h08;
   localparam logic [7:0] ASR_OFS_Y8 = 8'h09;
   localparam logic [7:0] ASR_OFS_Z8 = 8'h0a;
   localparam logic [7:0] ASR_OFS_CNT_LO = 8'h0c;
   localparam logic [7:0] ASR_OFS_CNT_HI = 8'h0d;
   localparam logic [7:0] ASR_OFS_X_HI = 8'h0e;
   localparam logic [7:0] ASR_OFS_X_LO = 8'h0f;
   localparam logic [7:0] ASR_OFS_Y_HI = 8'h10;
   localparam logic [7:0] ASR_OFS_Y_LO = 8'h11;
   localparam logic [7:0] ASR_OFS_Z_HI = 8'h12;
   localparam logic [7:0] ASR_OFS_Z_LO = 8'h13;
   localparam logic [7:0] ASR_OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] ASR_OFS_IRQ_MASK = 8'h21;
   localparam logic [7:0] ASR_OFS_STATUS = 8'h22;

   // Interrupt status bits
   localparam int ASR_IRQ_READY = 0;
   localparam int ASR_IRQ_OVER = 1;
   localparam int ASR_IRQ_W = 2;

   localparam logic [7:0] ASR_RST_BYTE = 8'h00;
   localparam logic [1:0] ASR_PAD_ZERO = 2'h0;
   localparam logic [5:0] ASR_HI_PAD = 6'h00;

   typedef enum logic [1:0] {
      ASR_AX_X = 2'b00,
      ASR_AX_Y = 2'b01,
      ASR_AX_Z = 2'b10,
      ASR_AX_NONE = 2'b11
   } asr_axis_t;
endpackage

// [hdl/asr_axis_hold.sv]
// Purpose: One axis sample holder with high/low snapshot
// Assumes: Same clock as the register port
// Notes: The high read freezes the low half until the low read
`timescale 1ns/100ps
module asr_axis_hold (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // New sample
   input wire logic load_i,
   input wire logic [13:0] sample_i,
   // Read events
   input wire logic read_hi_i,
   input wire logic read_lo_i,
   // Register views
   output logic [7:0] high_o,
   output logic [7:0] low_o,
   output logic [7:0] short_o
);
   import asr_pkg::*;

   typedef struct packed {
      logic [13:0] live;
      logic [5:0] low_snap;
      logic frozen;
   } asr_hold_t;

   asr_hold_t r;
   asr_hold_t next_r;

   always_comb begin
      next_r = r;
      if (load_i) begin
         next_r.live = sample_i;
      end
      // Latch the low bits of the same sample the high byte came from
      if (read_hi_i) begin
         next_r.low_snap = r.live[5:0];
         next_r.frozen = 1'b1;
      end else if (read_lo_i) begin
         next_r.frozen = 1'b0;
      end
      if (!rstn_i) begin
         next_r = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      r <= next_r;
   end

   assign high_o = r.live[13:6];
   assign low_o = {(r.frozen ? r.low_snap : r.live[5:0]), ASR_PAD_ZERO};
   assign short_o = r.live[13:6];
endmodule

// [hdl/asr_readout.sv]
// Purpose: Read-only count and acceleration sample registers with data-ready
// Assumes: Samples and FIFO count come from logic on core_clk_i
// Notes: Register port answers every read one cycle later; writes go to irq regs only
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Readout register block
// ----------------------------------------------------------------------------
module asr_readout (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Sample source
   input wire logic sample_valid_i,
   input wire logic [asr_pkg::ASR_SW-1:0] x_sample_i,
   input wire logic [asr_pkg::ASR_SW-1:0] y_sample_i,
   input wire logic [asr_pkg::ASR_SW-1:0] z_sample_i,
   input wire logic [asr_pkg::ASR_CW-1:0] fifo_fill_count_i,
   // Register port
   input wire logic [asr_pkg::ASR_AW-1:0] reg_addr_i,
   input wire logic [asr_pkg::ASR_DW-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [asr_pkg::ASR_DW-1:0] reg_rdata_o,
   // Status
   output logic data_ready_o,
   output logic irq_o
);
   import asr_pkg::*;

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [ASR_DW-1:0] rdata;
      logic [ASR_CW-1:0] count;
      logic ready;
      logic pend;
      logic in_read;
      asr_axis_t hi_axis;
      logic [ASR_IRQ_W-1:0] irq_stat;
      logic [ASR_IRQ_W-1:0] irq_mask;
      logic irq;
   } asr_state_t;

   asr_state_t r;
   asr_state_t next_r;

   logic [7:0] hi_v [3];
   logic [7:0] lo_v [3];
   logic [7:0] sh_v [3];
   logic [2:0] rd_hi;
   logic [2:0] rd_lo;
   logic data_rd;
   logic pair_done;
   logic [ASR_IRQ_W-1:0] irq_set;

   // -------------------------------------------------------------------------
   // Read decode
   // -------------------------------------------------------------------------
   assign rd_hi[0] = reg_rd_i && (reg_addr_i == ASR_OFS_X_HI);
   assign rd_hi[1] = reg_rd_i && (reg_addr_i == ASR_OFS_Y_HI);
   assign rd_hi[2] = reg_rd_i && (reg_addr_i == ASR_OFS_Z_HI);
   assign rd_lo[0] = reg_rd_i && (reg_addr_i == ASR_OFS_X_LO);
   assign rd_lo[1] = reg_rd_i && (reg_addr_i == ASR_OFS_Y_LO);
   assign rd_lo[2] = reg_rd_i && (reg_addr_i == ASR_OFS_Z_LO);
   // Any sample data register, 8-bit or 14-bit halves
   assign data_rd = reg_rd_i && (((reg_addr_i >= ASR_OFS_X8) && (reg_addr_i <= ASR_OFS_Z8))
                     || ((reg_addr_i >= ASR_OFS_X_HI) && (reg_addr_i <= ASR_OFS_Z_LO)));
   // Low read counts only when no other register access came between it and the matching high read
   assign pair_done = (rd_lo[0] && r.hi_axis == ASR_AX_X)
                    || (rd_lo[1] && r.hi_axis == ASR_AX_Y)
                    || (rd_lo[2] && r.hi_axis == ASR_AX_Z);

   // -------------------------------------------------------------------------
   // Axis holders
   // -------------------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_axis
      logic [ASR_SW-1:0] smp;
      assign smp = (i == 0) ? x_sample_i : ((i == 1) ? y_sample_i : z_sample_i);
      asr_axis_hold asr_axis_hold_inst (
         .core_clk_i(core_clk_i),
         .rstn_i(rstn_i),
         .load_i(sample_valid_i),
         .sample_i(smp),
         .read_hi_i(rd_hi[i]),
         .read_lo_i(rd_lo[i]),
         .high_o(hi_v[i]),
         .low_o(lo_v[i]),
         .short_o(sh_v[i])
      );
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      next_r = r;
      irq_set = '0;

      // Count clamped to the documented maximum
      if (sample_valid_i) begin
         next_r.count = (fifo_fill_count_i > ASR_COUNT_MAX) ? ASR_COUNT_MAX : fifo_fill_count_i;
      end

      // Pair tracking: only the access right after a high read can complete
      if (reg_rd_i) begin
         if (rd_hi[0]) begin
            next_r.hi_axis = ASR_AX_X;
         end else if (rd_hi[1]) begin
            next_r.hi_axis = ASR_AX_Y;
         end else if (rd_hi[2]) begin
            next_r.hi_axis = ASR_AX_Z;
         end else begin
            next_r.hi_axis = ASR_AX_NONE;
         end
      end else if (reg_wr_i) begin
         next_r.hi_axis = ASR_AX_NONE;
      end

      // Data-ready: a sample during a data read is held back until it ends
      next_r.in_read = data_rd;
      if (pair_done) begin
         next_r.ready = 1'b0;
      end
      if (sample_valid_i) begin
         if (data_rd) begin
            next_r.pend = 1'b1;
         end else begin
            // A fresh sample supersedes any deferred one, so it is flagged only once
            next_r.ready = 1'b1;
            next_r.pend = 1'b0;
            irq_set[ASR_IRQ_READY] = 1'b1;
            if (r.ready) begin
               irq_set[ASR_IRQ_OVER] = 1'b1;
            end
         end
      end else if (r.pend && !data_rd) begin
         next_r.ready = 1'b1;
         next_r.pend = 1'b0;
         irq_set[ASR_IRQ_READY] = 1'b1;
      end

      // Interrupt registers; set wins over write-one-to-clear
      if (reg_wr_i && reg_addr_i == ASR_OFS_IRQ_STAT) begin
         next_r.irq_stat = r.irq_stat & ~reg_wdata_i[ASR_IRQ_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == ASR_OFS_IRQ_MASK) begin
         next_r.irq_mask = reg_wdata_i[ASR_IRQ_W-1:0];
      end
      next_r.irq_stat = next_r.irq_stat | irq_set;
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

      // Read data, zero for unmapped addresses and outside reads
      next_r.rdata = ASR_RST_BYTE;
      if (reg_rd_i) begin
         case (reg_addr_i)
            ASR_OFS_X8: next_r.rdata = sh_v[0];
            ASR_OFS_Y8: next_r.rdata = sh_v[1];
            ASR_OFS_Z8: next_r.rdata = sh_v[2];
            ASR_OFS_CNT_LO: next_r.rdata = r.count[7:0];
            ASR_OFS_CNT_HI: next_r.rdata = {ASR_HI_PAD, r.count[9:8]};
            ASR_OFS_X_HI: next_r.rdata = hi_v[0];
            ASR_OFS_X_LO: next_r.rdata = lo_v[0];
            ASR_OFS_Y_HI: next_r.rdata = hi_v[1];
            ASR_OFS_Y_LO: next_r.rdata = lo_v[1];
            ASR_OFS_Z_HI: next_r.rdata = hi_v[2];
            ASR_OFS_Z_LO: next_r.rdata = lo_v[2];
            ASR_OFS_IRQ_STAT: next_r.rdata = {ASR_HI_PAD, r.irq_stat};
            ASR_OFS_IRQ_MASK: next_r.rdata = {ASR_HI_PAD, r.irq_mask};
            ASR_OFS_STATUS: next_r.rdata = {ASR_HI_PAD, r.pend, r.ready};
            default: next_r.rdata = ASR_RST_BYTE;
         endcase
      end

      if (!rstn_i) begin
         next_r = '0;
         next_r.hi_axis = ASR_AX_NONE;
      end
   end

   always_ff @(posedge core_clk_i) begin
      r <= next_r;
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign reg_rdata_o = r.rdata;
   assign data_ready_o = r.ready;
   assign irq_o = r.irq;
endmodule

// [sim/asr_readout_properties.sv]
// Purpose: Port checks for the readout registers
// Assumes: One clock, synchronous active-low reset
// Notes: Bound onto every readout block
`timescale 1ns/100ps
module asr_readout_properties (
   // Clock, reset and watched ports
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic sample_valid_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic data_ready_o
);
   default clocking dck @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   cnt_pad_a: assert property (reg_rd_i && reg_addr_i == 8'h0d |=> reg_rdata_o[7:2] == 6'h00)
      else $error("count pad bits set");
   cnt_max_a: assert property (reg_rd_i && reg_addr_i == 8'h0d |=> reg_rdata_o[1:0] != 2'h3)
      else $error("count above 512");
   low_pad_a:
      assert property (reg_rd_i && reg_addr_i inside {8'h0f, 8'h11, 8'h13} |=> reg_rdata_o[1:0] == 2'h0)
      else $error("low pad bits set");
   ready_set_a: assert property (sample_valid_i && !reg_rd_i |=> data_ready_o)
      else $error("ready not set");
   ready_hold_a: assert property (data_ready_o && !reg_rd_i |=> data_ready_o)
      else $error("ready lost without read");
   ready_defer_a:
      assert property (!data_ready_o && reg_rd_i && reg_addr_i inside {[8'h08:8'h0a], [8'h0e:8'h13]}
      |=> !data_ready_o)
      else $error("ready rose during read");
   // Guard against a deferred sample landing inside the pair
   pair_clear_a:
      assert property (!$past(reg_rd_i) && !$past(sample_valid_i) && !sample_valid_i && reg_rd_i
      && reg_addr_i inside {8'h0e, 8'h10, 8'h12} ##1 reg_rd_i && !sample_valid_i
      && reg_addr_i == $past(reg_addr_i) + 8'h01 |=> !data_ready_o)
      else $error("pair read left ready set");
   ready_fall_a:
      assert property ($fell(data_ready_o) |-> $past(reg_rd_i) && ($past(reg_addr_i) inside {8'h0f, 8'h11, 8'h13}))
      else $error("ready fell without low read");
endmodule
bind asr_readout asr_readout_properties asr_readout_properties_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
   .sample_valid_i(sample_valid_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .data_ready_o(data_ready_o));

// [sim/asr_host_model.sv]
// Purpose: Host processor model on the register port
// Assumes: One transfer at a time from the bench
// Notes: Bursts keep reads adjacent so high/low pairs complete
`timescale 1ns/100ps
module asr_host_model (
   // Clock
   input wire logic clk_i,
   // Register port
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   logic [7:0] q [0:15];
   initial begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
   end
   // Answer of each strobe is taken one edge later
   task automatic rd(input logic [7:0] a, input int n);
      @(posedge clk_i);
      for (int i = 0; i <= n; i++) begin
         if (i < n) begin
            addr_o <= a + 8'(i);
            rd_o <= 1'b1;
         end else begin
            rd_o <= 1'b0;
            addr_o <= ~addr_o;
         end
         @(posedge clk_i);
         if (i > 0) q[i-1] = rdata_i;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
      @(posedge clk_i);
      wr_o <= 1'b0;
   endtask
endmodule

// [sim/test_asr_readout.sv]
// Purpose: Self-checking bench for the readout registers
// Assumes: Host model owns the register port
// Notes: Expected bytes are hand-worked from the samples, count, status and interrupt registers
`timescale 1ns/100ps
module test_asr_readout;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic sv = 1'b0;
   logic [13:0] xs = 14'h0;
   logic [13:0] ys = 14'h0;
   logic [13:0] zs = 14'h0;
   logic [9:0] cnt = 10'h0;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   logic ready;
   logic irq;
   int fail_count = 0;
   int comparisons = 0;
   always #10 core_clk_i = ~core_clk_i;
   asr_readout asr_readout_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sample_valid_i(sv),
      .x_sample_i(xs), .y_sample_i(ys), .z_sample_i(zs), .fifo_fill_count_i(cnt), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .data_ready_o(ready), .irq_o(irq));
   asr_host_model asr_host_model_inst (.clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic put(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z, input logic [9:0] c);
      @(posedge core_clk_i);
      {xs, ys, zs, cnt, sv} <= {x, y, z, c, 1'b1};
      @(posedge core_clk_i);
      sv <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e [$]);
      asr_host_model_inst.rd(a, e.size());
      for (int i = 0; i < e.size(); i++) chk($sformatf("reg %h", a + 8'(i)), asr_host_model_inst.q[i], e[i]);
   endtask
   task automatic rdy(input logic e);
      #1 chk("ready", {7'h0, ready}, {7'h0, e});
   endtask
   task automatic irqc(input logic e);
      @(posedge core_clk_i);
      #1 chk("irq", {7'h0, irq}, {7'h0, e});
   endtask
   // Bounded wait: running out ends the run
   task automatic wait_ready();
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk_i);
         #1;
         if (ready === 1'b1) return;
      end
      fail_count++;
      close_out();
   endtask
   task automatic t_basic();
      rdc(8'h08, '{12{8'h00}});
      rdy(1'b0);
      put(14'h2a5c, 14'h0123, 14'h3fc1, 10'h1ff);
      rdy(1'b1);
      rdc(8'h08, '{8'ha9, 8'h04, 8'hff, 8'h00, 8'hff, 8'h01, 8'ha9, 8'h70});
      rdy(1'b0);
      $display("test basic done");
   endtask
   task automatic t_defer();
      fork
         asr_host_model_inst.rd(8'h10, 1);
         begin
            @(posedge core_clk_i);
            {ys, sv} <= {14'h1555, 1'b1};
            @(posedge core_clk_i);
            sv <= 1'b0;
            rdy(1'b0);
         end
      join
      wait_ready();
      rdc(8'h22, '{8'h01});
      rdc(8'h10, '{8'h55, 8'h54});
      rdy(1'b0);
      $display("test defer done");
   endtask
   task automatic t_snap();
      put(14'h0, 14'h0, 14'h0abc, 10'h200);
      rdc(8'h12, '{8'h2a});
      put(14'h0, 14'h0, 14'h3003, 10'h3ff);
      rdc(8'h13, '{8'hf0});
      rdc(8'h0c, '{8'h00, 8'h02});
      put(14'h0, 14'h0, 14'h3003, 10'h3ff);
      rdy(1'b1);
      rdc(8'h12, '{8'hc0, 8'h0c});
      rdy(1'b0);
      $display("test snapshot done");
   endtask
   task automatic t_irq();
      asr_host_model_inst.wr(8'h20, 8'h03);
      asr_host_model_inst.wr(8'h21, 8'h01);
      irqc(1'b0);
      put(14'h1234, 14'h0, 14'h0, 10'h0);
      irqc(1'b1);
      asr_host_model_inst.wr(8'h20, 8'h03);
      irqc(1'b0);
      asr_host_model_inst.wr(8'h21, 8'h00);
      put(14'h1234, 14'h0, 14'h0, 10'h0);
      irqc(1'b0);
      rdc(8'h20, '{8'h03, 8'h00});
      asr_host_model_inst.wr(8'h0e, 8'h55);
      rdc(8'h0e, '{8'h48});
      $display("test irq done");
   endtask
   initial begin
      repeat (20) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      t_basic();
      t_defer();
      t_snap();
      t_irq();
      close_out();
   end
endmodule
